// ==== inc/pin_cfg_pkg.sv ====
// Package with register map, field layout and reset values of the pin and power-good routing block
// Notes on behaviour
// - Bit 7 of the pin configuration register reads the live pin level: 0 when low, 1 when high or released.
// - With output value 0 the pin is pulled to ground, with 1 it is driven high in push-pull or released in open-drain.
// - Output type bit 3 picks push-pull to the buck-one rail at 0 and open-drain at 1.
// - Direction bit 2 at 0 makes the pin high impedance with the input buffer on, at 1 enables the output buffer.
// - Output value and output type matter only while the pin is an output and are ignored while it is an input.
// - Bit 1 connects a pull resistor when 1 and none when 0, and only while the pin is an input.
// - Bit 0 selects a pulldown at 0 and a pullup to the internal supply at 1, only while a resistor is present.
// - The read-only status register shows in bit 5 whether the USB-ok pin interrupt is active.
// - Status bits 0, 1 and 2 show whether the pin power-good interrupts of bucks one, two and three are active.
// - Bit 7 of the buck-one routing register reads 1 once a buck-one power-good change has raised an interrupt.
// - Bit 6 of the buck-one routing register sends the buck-one power-good interrupt to pin six when set.
// - Bits 5 down to 0 of the buck-one routing register send that interrupt to pins five down to zero when set.
package pin_cfg_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 8;
	localparam int          ROUTE_PINS       = 7;
	localparam int          SYNC_W           = 5;

	// Register offsets
	localparam logic [7:0]  PIN_SEVEN_CONFIG_ADDR        = 8'h6e;
	localparam logic [7:0]  PIN_IRQ_STATUS_ADDR          = 8'h6f;
	localparam logic [7:0]  BUCK_ONE_PG_IRQ_ROUTING_ADDR = 8'h70;

	// Pin configuration fields
	localparam int          CFG_READBACK_BIT = 7;
	localparam int          CFG_OUT_VAL_BIT  = 4;
	localparam int          CFG_OD_BIT       = 3;
	localparam int          CFG_OE_BIT       = 2;
	localparam int          CFG_PULL_EN_BIT  = 1;
	localparam int          CFG_PULL_POL_BIT = 0;
	localparam logic [7:0]  CFG_WR_MASK      = 8'h1f;

	// Status fields
	localparam int          STS_USB_OK_BIT   = 5;
	localparam int          STS_BUCK3_BIT    = 2;
	localparam int          STS_BUCK2_BIT    = 1;
	localparam int          STS_BUCK1_BIT    = 0;

	// Routing fields
	localparam int          ROUTE_FLAG_BIT   = 7;
	localparam logic [7:0]  ROUTE_WR_MASK    = 8'h7f;

	// Reset values
	localparam logic [4:0]  CFG_RESET        = 5'h00;
	localparam logic [6:0]  ROUTE_RESET      = 7'h00;
	localparam logic [7:0]  RDATA_RESET      = 8'h00;

	// Synchroniser lane order
	localparam int          SYN_PAD          = 0;
	localparam int          SYN_BUCK1_PG     = 1;
	localparam int          SYN_BUCK2_IRQ    = 2;
	localparam int          SYN_BUCK3_IRQ    = 3;
	localparam int          SYN_USB_IRQ      = 4;
endpackage

// ==== tb/pin_load.sv ====
// Board side of multi purpose pin seven: device driver, outside driver, on-chip and board pulls
`timescale 1ns/1ps
module pin_load #(
	parameter logic BOARD_PULL = 1'b1
) (
	// Device pad outputs
	input  wire logic pad_out,
	input  wire logic pad_oe_n,
	input  wire logic pad_pull_up,
	input  wire logic pad_pull_down,
	// Outside driver, only used while the device has released the pin
	input  wire logic ext_en,
	input  wire logic ext_level,
	// Resolved wire level
	output logic      pad_level
);
	// A released pin with nothing on it sits at the board pull, never at a stale value
	always_comb begin
		if (!pad_oe_n) begin
			pad_level = pad_out;
		end else if (ext_en) begin
			pad_level = ext_level;
		end else if (pad_pull_up) begin
			pad_level = 1'b1;
		end else if (pad_pull_down) begin
			pad_level = 1'b0;
		end else begin
			pad_level = BOARD_PULL;
		end
	end
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench for the pin configuration and power-good routing block
`timescale 1ns/1ps
module testbench;
	import pin_cfg_pkg::*;
	logic       core_clk;
	logic       rstn;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic       pad_in;
	logic       pad_out;
	logic       pad_oe_n;
	logic       pad_pull_up;
	logic       pad_pull_down;
	logic       buck_one_pg;
	logic [2:0] sts;
	logic [6:0] other_route_irq;
	logic [6:0] pin_route_irq;
	logic       ext_en;
	logic       ext_level;
	int         n_errors;
	int         n_tests;
	int         i;
	integer     seed;
	logic [7:0] d;
	logic [7:0] q;
	logic [4:0] c;
	logic [3:0] p;
	logic       e;
	logic [6:0] o;
	logic [7:0] corner [8];

	pin_cfg_top dut (
		.core_clk             (core_clk),
		.rstn                 (rstn),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.reg_rvalid           (reg_rvalid),
		.pad_in               (pad_in),
		.pad_out              (pad_out),
		.pad_oe_n             (pad_oe_n),
		.pad_pull_up          (pad_pull_up),
		.pad_pull_down        (pad_pull_down),
		.buck_one_pg          (buck_one_pg),
		.buck_two_irq_level   (sts[0]),
		.buck_three_irq_level (sts[1]),
		.usb_input_valid_irq  (sts[2]),
		.other_route_irq      (other_route_irq),
		.pin_route_irq        (pin_route_irq)
	);

	pin_load load (
		.pad_out       (pad_out),
		.pad_oe_n      (pad_oe_n),
		.pad_pull_up   (pad_pull_up),
		.pad_pull_down (pad_pull_down),
		.ext_en        (ext_en),
		.ext_level     (ext_level),
		.pad_level     (pad_in)
	);

	// Expected {oe_n, pull_up, pull_down, device drives}
	function automatic logic [3:0] exp_pad(input logic [4:0] cf);
		logic drv;
		drv = cf[CFG_OE_BIT] && !(cf[CFG_OD_BIT] && cf[CFG_OUT_VAL_BIT]);
		return {!drv, !cf[CFG_OE_BIT] && cf[CFG_PULL_EN_BIT] && cf[CFG_PULL_POL_BIT],
			!cf[CFG_OE_BIT] && cf[CFG_PULL_EN_BIT] && !cf[CFG_PULL_POL_BIT], drv};
	endfunction

	function automatic logic exp_lvl(input logic [4:0] cf, input logic xe, input logic xl);
		if (exp_pad(cf) & 4'h1) return cf[CFG_OUT_VAL_BIT];
		if (xe) return xl;
		if (!cf[CFG_OE_BIT] && cf[CFG_PULL_EN_BIT]) return cf[CFG_PULL_POL_BIT];
		return 1'b1;
	endfunction

	function automatic logic [7:0] exp_sts(input logic [2:0] s, input logic f);
		return {2'b00, s[2], 2'b00, s[1], s[0], f};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= dat;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data is taken one cycle after the strobe, while rvalid stands
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check({7'h00, reg_rvalid}, 8'h01);
		check(reg_rdata, exp);
	endtask

	task automatic results;
		if (n_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		#200000;
		n_errors++;
		results();
	end

	initial begin
		seed = 46884;
		n_errors = 0;
		n_tests = 0;
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		buck_one_pg = 1'b0;
		sts = 3'h0;
		other_route_irq = 7'h00;
		ext_en = 1'b0;
		ext_level = 1'b0;
		// Every output mode, both pulls, polarity without resistor, reserved bits set
		corner = '{8'h04, 8'h14, 8'h0c, 8'h1c, 8'h02, 8'h03, 8'h01, 8'hf7};
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check({5'h00, pad_oe_n, pad_pull_up, pad_pull_down}, 8'h04);
		rchk(PIN_SEVEN_CONFIG_ADDR, 8'h80);
		rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, 8'h00);
		for (i = 0; i < 40; i++) begin
			d = (i < 8) ? corner[i] : 8'($random(seed));
			c = d[4:0];
			p = exp_pad(c);
			e = 1'($random(seed));
			e = e && !p[0];
			wr(PIN_SEVEN_CONFIG_ADDR, d);
			ext_en <= e;
			ext_level <= 1'($random(seed));
			sts <= 3'($random(seed));
			other_route_irq <= 7'($random(seed));
			repeat (3) @(posedge core_clk);
			#1;
			check({5'h00, pad_oe_n, pad_pull_up, pad_pull_down}, {5'h00, p[3:1]});
			if (p[0]) check({7'h00, pad_out}, {7'h00, c[CFG_OUT_VAL_BIT]});
			check({1'b0, pin_route_irq}, {1'b0, other_route_irq});
			rchk(PIN_SEVEN_CONFIG_ADDR, {exp_lvl(c, e, ext_level), 2'b00, c});
			rchk(PIN_IRQ_STATUS_ADDR, exp_sts(sts, 1'b0));
		end
		ext_en <= 1'b0;
		// Even number of power-good toggles leaves the level low for the final reset
		for (i = 0; i < 12; i++) begin
			d = (i == 0) ? 8'hff : 8'($random(seed));
			o = (i == 0) ? 7'h00 : 7'($random(seed));
			wr(BUCK_ONE_PG_IRQ_ROUTING_ADDR, d);
			other_route_irq <= o;
			buck_one_pg <= ~buck_one_pg;
			repeat (6) @(posedge core_clk);
			#1;
			check({1'b0, pin_route_irq}, {1'b0, d[6:0] | o});
			rchk(PIN_IRQ_STATUS_ADDR, exp_sts(sts, 1'b1));
			rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, {1'b1, d[6:0]});
			rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, {1'b0, d[6:0]});
			@(posedge core_clk);
			#1;
			check({1'b0, pin_route_irq}, {1'b0, o});
		end
		// Change lands in the cycle of the clearing read: the set must win
		for (i = 0; i < 2; i++) begin
			@(posedge core_clk);
			buck_one_pg <= ~buck_one_pg;
			@(posedge core_clk);
			rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, {1'b0, d[6:0]});
			rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, {1'b1, d[6:0]});
			rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, {1'b0, d[6:0]});
		end
		wr(PIN_IRQ_STATUS_ADDR, 8'hff);
		wr(8'h71, 8'hff);
		rchk(8'h71, 8'h00);
		rchk(PIN_IRQ_STATUS_ADDR, exp_sts(sts, 1'b0));
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rchk(PIN_SEVEN_CONFIG_ADDR, 8'h80);
		rchk(BUCK_ONE_PG_IRQ_ROUTING_ADDR, 8'h00);
		results();
	end
endmodule

// ==== verilog/pin_cfg_top.sv ====
// Pin seven configuration, pin power-good status and buck-one interrupt routing
`timescale 1ns/1ps
module pin_cfg_top (
	// Clock and reset
	input  wire logic                                    core_clk,
	input  wire logic                                    rstn,
	// Register port from the serial front end
	input  wire logic [pin_cfg_pkg::ADDR_W-1:0]          reg_addr,
	input  wire logic [pin_cfg_pkg::DATA_W-1:0]          reg_wdata,
	input  wire logic                                    reg_wr,
	input  wire logic                                    reg_rd,
	output logic      [pin_cfg_pkg::DATA_W-1:0]          reg_rdata,
	output logic                                         reg_rvalid,
	// Pad of multi purpose pin seven
	input  wire logic                                    pad_in,
	output logic                                         pad_out,
	output logic                                         pad_oe_n,
	output logic                                         pad_pull_up,
	output logic                                         pad_pull_down,
	// Regulator and USB status levels
	input  wire logic                                    buck_one_pg,
	input  wire logic                                    buck_two_irq_level,
	input  wire logic                                    buck_three_irq_level,
	input  wire logic                                    usb_input_valid_irq,
	// Interrupt routing toward pins zero to six
	input  wire logic [pin_cfg_pkg::ROUTE_PINS-1:0]      other_route_irq,
	output logic      [pin_cfg_pkg::ROUTE_PINS-1:0]      pin_route_irq
);
	import pin_cfg_pkg::*;

	logic [SYNC_W-1:0]     sync_lvl;
	logic                  pin_output_value_ff;
	logic                  pin_open_drain_select_ff;
	logic                  pin_output_enable_ff;
	logic                  pin_pull_present_ff;
	logic                  pin_pull_polarity_ff;
	logic                  nxt_pin_output_value;
	logic                  nxt_pin_open_drain_select;
	logic                  nxt_pin_output_enable;
	logic                  nxt_pin_pull_present;
	logic                  nxt_pin_pull_polarity;
	logic [ROUTE_PINS-1:0] route_sel_ff;
	logic [ROUTE_PINS-1:0] nxt_route_sel;
	logic                  buck_one_pg_change_flag_ff;
	logic                  nxt_buck_one_pg_change_flag;
	logic                  buck_one_pg_prev_ff;
	logic                  nxt_buck_one_pg_prev;
	logic [DATA_W-1:0]     rdata_ff;
	logic [DATA_W-1:0]     nxt_rdata;
	logic                  rvalid_ff;
	logic                  nxt_rvalid;
	logic                  pad_out_ff;
	logic                  pad_oe_n_ff;
	logic                  pull_up_ff;
	logic                  pull_down_ff;
	logic                  nxt_pad_out;
	logic                  nxt_pad_oe_n;
	logic                  nxt_pull_up;
	logic                  nxt_pull_down;
	logic [ROUTE_PINS-1:0] route_irq_ff;
	logic [ROUTE_PINS-1:0] nxt_route_irq;
	logic                  pg_change;
	logic                  flag_clear;
	logic [DATA_W-1:0]     cfg_view;
	logic [DATA_W-1:0]     sts_view;
	logic [DATA_W-1:0]     route_view;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Pin and regulator levels come from other domains
	pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.async_in ({usb_input_valid_irq, buck_three_irq_level, buck_two_irq_level, buck_one_pg, pad_in}),
		.sync_out (sync_lvl)
	);

	// Register views; reserved bits are zero
	always_comb begin
		cfg_view                   = '0;
		cfg_view[CFG_READBACK_BIT] = sync_lvl[SYN_PAD];
		cfg_view[CFG_OUT_VAL_BIT]  = pin_output_value_ff;
		cfg_view[CFG_OD_BIT]       = pin_open_drain_select_ff;
		cfg_view[CFG_OE_BIT]       = pin_output_enable_ff;
		cfg_view[CFG_PULL_EN_BIT]  = pin_pull_present_ff;
		cfg_view[CFG_PULL_POL_BIT] = pin_pull_polarity_ff;
		sts_view                   = '0;
		sts_view[STS_USB_OK_BIT]   = sync_lvl[SYN_USB_IRQ];
		sts_view[STS_BUCK3_BIT]    = sync_lvl[SYN_BUCK3_IRQ];
		sts_view[STS_BUCK2_BIT]    = sync_lvl[SYN_BUCK2_IRQ];
		sts_view[STS_BUCK1_BIT]    = buck_one_pg_change_flag_ff;
		route_view                 = {buck_one_pg_change_flag_ff, route_sel_ff};
	end

	// Configuration and routing registers
	always_comb begin
		nxt_pin_output_value      = pin_output_value_ff;
		nxt_pin_open_drain_select = pin_open_drain_select_ff;
		nxt_pin_output_enable     = pin_output_enable_ff;
		nxt_pin_pull_present      = pin_pull_present_ff;
		nxt_pin_pull_polarity     = pin_pull_polarity_ff;
		nxt_route_sel             = route_sel_ff;
		// Masked writes keep read-only and reserved bits out
		if (reg_wr && hit(reg_addr, PIN_SEVEN_CONFIG_ADDR)) begin
			nxt_pin_output_value      = reg_wdata[CFG_OUT_VAL_BIT] & CFG_WR_MASK[CFG_OUT_VAL_BIT];
			nxt_pin_open_drain_select = reg_wdata[CFG_OD_BIT];
			nxt_pin_output_enable     = reg_wdata[CFG_OE_BIT];
			nxt_pin_pull_present      = reg_wdata[CFG_PULL_EN_BIT];
			nxt_pin_pull_polarity     = reg_wdata[CFG_PULL_POL_BIT];
		end
		if (reg_wr && hit(reg_addr, BUCK_ONE_PG_IRQ_ROUTING_ADDR)) begin
			nxt_route_sel = reg_wdata[ROUTE_PINS-1:0] & ROUTE_WR_MASK[ROUTE_PINS-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_output_value_ff      <= CFG_RESET[CFG_OUT_VAL_BIT];
			pin_open_drain_select_ff <= CFG_RESET[CFG_OD_BIT];
			pin_output_enable_ff     <= CFG_RESET[CFG_OE_BIT];
			pin_pull_present_ff      <= CFG_RESET[CFG_PULL_EN_BIT];
			pin_pull_polarity_ff     <= CFG_RESET[CFG_PULL_POL_BIT];
			route_sel_ff             <= ROUTE_RESET;
		end else begin
			pin_output_value_ff      <= nxt_pin_output_value;
			pin_open_drain_select_ff <= nxt_pin_open_drain_select;
			pin_output_enable_ff     <= nxt_pin_output_enable;
			pin_pull_present_ff      <= nxt_pin_pull_present;
			pin_pull_polarity_ff     <= nxt_pin_pull_polarity;
			route_sel_ff             <= nxt_route_sel;
		end
	end

	// Power-good change flag, cleared by reading the routing register
	assign pg_change  = sync_lvl[SYN_BUCK1_PG] ^ buck_one_pg_prev_ff;
	assign flag_clear = reg_rd && hit(reg_addr, BUCK_ONE_PG_IRQ_ROUTING_ADDR);

	always_comb begin
		nxt_buck_one_pg_prev        = sync_lvl[SYN_BUCK1_PG];
		nxt_buck_one_pg_change_flag = buck_one_pg_change_flag_ff;
		if (flag_clear) begin
			nxt_buck_one_pg_change_flag = 1'b0;
		end
		// A change in the clearing cycle must not be lost
		if (pg_change) begin
			nxt_buck_one_pg_change_flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			buck_one_pg_prev_ff        <= 1'b0;
			buck_one_pg_change_flag_ff <= 1'b0;
		end else begin
			buck_one_pg_prev_ff        <= nxt_buck_one_pg_prev;
			buck_one_pg_change_flag_ff <= nxt_buck_one_pg_change_flag;
		end
	end

	// Read port: data one cycle after the strobe, zero for unmapped offsets
	always_comb begin
		nxt_rvalid = reg_rd;
		nxt_rdata  = rdata_ff;
		if (reg_rd) begin
			if (hit(reg_addr, PIN_SEVEN_CONFIG_ADDR)) begin
				nxt_rdata = cfg_view;
			end else if (hit(reg_addr, PIN_IRQ_STATUS_ADDR)) begin
				nxt_rdata = sts_view;
			end else if (hit(reg_addr, BUCK_ONE_PG_IRQ_ROUTING_ADDR)) begin
				nxt_rdata = route_view;
			end else begin
				nxt_rdata = RDATA_RESET;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff  <= RDATA_RESET;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// Pad drive and pull network
	always_comb begin
		nxt_pad_out   = 1'b0;
		nxt_pad_oe_n  = 1'b1;
		nxt_pull_up   = 1'b0;
		nxt_pull_down = 1'b0;
		if (pin_output_enable_ff) begin
			if (!pin_open_drain_select_ff) begin
				nxt_pad_out  = pin_output_value_ff;
				nxt_pad_oe_n = 1'b0;
			end else begin
				// Open drain only ever sinks, a high value releases the pad
				nxt_pad_out  = 1'b0;
				nxt_pad_oe_n = pin_output_value_ff;
			end
		end else if (pin_pull_present_ff) begin
			nxt_pull_up   = pin_pull_polarity_ff;
			nxt_pull_down = ~pin_pull_polarity_ff;
		end
	end

	// Routed interrupt is ORed with other_route_irq on pins zero to six
	always_comb begin
		nxt_route_irq = ({ROUTE_PINS{buck_one_pg_change_flag_ff}} & route_sel_ff) | other_route_irq;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pad_out_ff   <= 1'b0;
			pad_oe_n_ff  <= 1'b1;
			pull_up_ff   <= 1'b0;
			pull_down_ff <= 1'b0;
			route_irq_ff <= '0;
		end else begin
			pad_out_ff   <= nxt_pad_out;
			pad_oe_n_ff  <= nxt_pad_oe_n;
			pull_up_ff   <= nxt_pull_up;
			pull_down_ff <= nxt_pull_down;
			route_irq_ff <= nxt_route_irq;
		end
	end

	assign reg_rdata     = rdata_ff;
	assign reg_rvalid    = rvalid_ff;
	assign pad_out       = pad_out_ff;
	assign pad_oe_n      = pad_oe_n_ff;
	assign pad_pull_up   = pull_up_ff;
	assign pad_pull_down = pull_down_ff;
	assign pin_route_irq = route_irq_ff;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	AST_READBACK: assert property (reg_rd && hit(reg_addr, PIN_SEVEN_CONFIG_ADDR) |=>
		reg_rdata[CFG_READBACK_BIT] == $past(sync_lvl[SYN_PAD]))
		else $error("Pin level readback wrong");
	AST_PUSH_PULL: assert property (pin_output_enable_ff && !pin_open_drain_select_ff |=>
		!pad_oe_n && pad_out == $past(pin_output_value_ff))
		else $error("Push-pull drive wrong");
	AST_OPEN_DRAIN: assert property (pin_output_enable_ff && pin_open_drain_select_ff |=>
		!pad_out && pad_oe_n == $past(pin_output_value_ff))
		else $error("Open-drain drive wrong");
	AST_INPUT_HIZ: assert property (!pin_output_enable_ff |=> pad_oe_n)
		else $error("Input pin is driven");
	AST_INPUT_IGNORES: assert property (!pin_output_enable_ff && $changed(pin_output_value_ff) |=>
		pad_oe_n && !pad_out)
		else $error("Output fields act on input pin");
	AST_PULL_ONLY_INPUT: assert property (pad_pull_up || pad_pull_down |->
		!$past(pin_output_enable_ff) && $past(pin_pull_present_ff))
		else $error("Pull active outside input mode");
	AST_PULL_POLARITY: assert property (!pin_output_enable_ff && pin_pull_present_ff |=>
		pad_pull_up == $past(pin_pull_polarity_ff) && pad_pull_down != pad_pull_up)
		else $error("Pull polarity wrong");
	AST_STATUS_USB: assert property (reg_rd && hit(reg_addr, PIN_IRQ_STATUS_ADDR) |=>
		reg_rdata[STS_USB_OK_BIT] == $past(sync_lvl[SYN_USB_IRQ]) && reg_rdata[7:6] == 2'b00)
		else $error("USB status bit wrong");
	AST_STATUS_BUCKS: assert property (reg_rd && hit(reg_addr, PIN_IRQ_STATUS_ADDR) |=>
		reg_rdata[STS_BUCK3_BIT] == $past(sync_lvl[SYN_BUCK3_IRQ]) &&
		reg_rdata[STS_BUCK2_BIT] == $past(sync_lvl[SYN_BUCK2_IRQ]))
		else $error("Buck status bits wrong");
	AST_FLAG_SET: assert property (pg_change |=> buck_one_pg_change_flag_ff)
		else $error("Power-good change not flagged");
	AST_ROUTE: assert property (buck_one_pg_change_flag_ff && route_sel_ff[ROUTE_PINS-1] |=>
		pin_route_irq[ROUTE_PINS-1])
		else $error("Pin six routing lost");
	AST_ROUTE_LOW: assert property (!buck_one_pg_change_flag_ff && other_route_irq == '0 |=>
		pin_route_irq == '0)
		else $error("Spurious routed interrupt");
	AST_HOLD: assert property (!reg_wr |=> $stable(route_sel_ff) && $stable(pin_output_value_ff))
		else $error("Configuration changed without write");
	AST_FLAG_CLEAR: assert property (flag_clear && !pg_change |=> !buck_one_pg_change_flag_ff)
		else $error("Change flag survived its clearing read");
	AST_CFG_RESERVED: assert property (reg_rd && hit(reg_addr, PIN_SEVEN_CONFIG_ADDR) |=>
		reg_rdata[6:5] == 2'b00)
		else $error("Reserved configuration bits not zero");
	AST_STATUS_BUCK1: assert property (reg_rd && hit(reg_addr, PIN_IRQ_STATUS_ADDR) |=>
		reg_rdata[STS_BUCK1_BIT] == $past(buck_one_pg_change_flag_ff) && reg_rdata[4:3] == 2'b00)
		else $error("Buck-one status bit wrong");
	AST_CFG_WRITE: assert property (reg_wr && hit(reg_addr, PIN_SEVEN_CONFIG_ADDR) |=>
		pin_output_value_ff == $past(reg_wdata[CFG_OUT_VAL_BIT]) && pin_output_enable_ff == $past(reg_wdata[CFG_OE_BIT]))
		else $error("Configuration write lost");
	AST_ROUTE_WRITE: assert property (reg_wr && hit(reg_addr, BUCK_ONE_PG_IRQ_ROUTING_ADDR) |=>
		route_sel_ff == $past(reg_wdata[ROUTE_PINS-1:0]))
		else $error("Routing write lost");

	COV_OPEN_DRAIN: cover property (pin_output_enable_ff && pin_open_drain_select_ff ##1 pad_oe_n);
	COV_PULLUP: cover property (pad_pull_up);
	COV_FLAG_CLEAR: cover property (buck_one_pg_change_flag_ff && flag_clear ##1 !buck_one_pg_change_flag_ff);
	COV_ROUTED: cover property (pin_route_irq[0]);
	COV_SET_WINS: cover property (flag_clear && pg_change ##1 buck_one_pg_change_flag_ff);
endmodule

// ==== verilog/pin_sync.sv ====
// Two-stage synchroniser for pin and regulator levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// First stage feeds only the second one
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
